/* spsel_page_select.sv */
// spsel_page_select: sram page choice, flag save/restore, stack pointer,
// and the three-access auto_increment_move sequencer.
// assumes the cpu core drives single-cycle requests synchronous to sys_clk_i
// and that register writes arrive as plain strobes with data.
// Contract
// - reset clears page mode bits to 00
// - stack page from stack_page_pointer low bits
// - stack instructions use stack page, mode kept
// - stack pointer wraps within one page
// - interrupt pushes flags then clears them
// - return restores saved flag register value
// - return restores saved mode despite handler changes
// - move: pointer read, pointer write, data access
// - move read/write pages from respective pointers
// - move pointers apply regardless of mode
// - normal page: 0 or current by upper bit
// - indexed page follows page mode table
// - indexed register space access is never paged
// - supervisor call runs with mode 00
// - current pointer acts only in modes 10/11
// - stack page pointer resets to zero
module spsel_page_select
    import spsel_pkg::*;
#(
    parameter int PAGE_W = SPSEL_PAGE_W,  // page number width
    parameter int ADDR_W = SPSEL_ADDR_W   // data address width
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rstn_i,
    // access request from the cpu core
    input  wire logic                     acc_valid_i,
    input  wire spsel_acc_t               acc_kind_i,
    input  wire logic                     acc_reg_space_i,
    input  wire logic [ADDR_W-1:0]        acc_addr_i,
    // page pointer register writes
    input  wire logic                     current_page_pointer_we_i,
    input  wire logic                     stack_page_pointer_we_i,
    input  wire logic                     index_page_pointer_we_i,
    input  wire logic                     move_read_page_pointer_we_i,
    input  wire logic                     move_write_page_pointer_we_i,
    input  wire logic [PAGE_W-1:0]        pp_wdata_i,
    // flag register write by software
    input  wire logic                     flag_we_i,
    input  wire logic [7:0]               flag_wdata_i,
    // control flow events
    input  wire logic                     irq_entry_i,
    input  wire logic                     return_from_interrupt_i,
    input  wire logic [7:0]               return_from_interrupt_flag_i,
    input  wire logic                     svc_entry_i,
    input  wire logic                     sp_push_i,
    input  wire logic                     sp_pop_i,
    // auto_increment_move start: 1 = read into accumulator
    input  wire logic                     mv_start_i,
    input  wire logic                     mv_is_read_i,
    input  wire logic [ADDR_W-1:0]        mv_ptr_addr_i,
    input  wire logic [ADDR_W-1:0]        mv_ptr_rdata_i,
    // sram side
    output logic                          sram_en_o,
    output logic                          sram_we_o,
    output logic [PAGE_W+ADDR_W-1:0]      sram_addr_o,
    output logic [ADDR_W-1:0]             sram_wdata_o,
    output logic                          reg_en_o,
    output logic [ADDR_W-1:0]             reg_addr_o,
    // state seen by the core
    output logic [7:0]                    flag_o,
    output logic [7:0]                    flag_push_o,
    output logic [ADDR_W-1:0]             stack_pointer_o,
    output logic [PAGE_W-1:0]             stack_page_pointer_o,
    output logic                          mv_busy_o
);

    // whole block state in one packed struct
    typedef struct packed {
        logic [7:0]              flag;
        logic [7:0]              flag_push;
        logic [ADDR_W-1:0]       sp;
        logic [PAGE_W-1:0]       current_page_pointer;
        logic [PAGE_W-1:0]       stack_page_pointer;
        logic [PAGE_W-1:0]       index_page_pointer;
        logic [PAGE_W-1:0]       move_read_page_pointer;
        logic [PAGE_W-1:0]       move_write_page_pointer;
        spsel_mv_t               mv_st;
        logic                    mv_rd;
        logic [ADDR_W-1:0]       mv_ptr;
        logic [ADDR_W-1:0]       mv_data_addr;
        logic                    sram_en;
        logic                    sram_we;
        logic [PAGE_W+ADDR_W-1:0] sram_addr;
        logic [ADDR_W-1:0]       sram_wdata;
        logic                    reg_en;
        logic [ADDR_W-1:0]       reg_addr;
    } spsel_state_t;

    spsel_state_t st_reg;   // registered state
    spsel_state_t st_next;  // next state

    logic [1:0]         mode;       // page mode bits of the flag register
    logic [PAGE_W-1:0]  page_sel;   // page for a cpu request

    assign mode = st_reg.flag[SPSEL_MODE_HI:SPSEL_MODE_LO];

    // page choice for a single cpu access
    always_comb begin
        case (acc_kind_i)
            SPSEL_ACC_STACK: begin
                page_sel = st_reg.stack_page_pointer;
            end
            SPSEL_ACC_INDEX: begin
                case (mode)
                    SPSEL_PM_00: page_sel = SPSEL_PAGE0[PAGE_W-1:0];
                    SPSEL_PM_01: page_sel = st_reg.stack_page_pointer;
                    SPSEL_PM_10: page_sel = st_reg.index_page_pointer;
                    default:     page_sel = st_reg.stack_page_pointer;
                endcase
            end
            SPSEL_ACC_MVRD: begin
                page_sel = st_reg.move_read_page_pointer;
            end
            SPSEL_ACC_MVWR: begin
                page_sel = st_reg.move_write_page_pointer;
            end
            default: begin
                // normal and move pointer accesses use the current page in modes 10/11, page zero in modes 00/01
                page_sel = mode[1] ? st_reg.current_page_pointer
                                   : SPSEL_PAGE0[PAGE_W-1:0];
            end
        endcase
    end

    // next state: registers, flags, stack pointer, move sequence
    always_comb begin
        st_next         = st_reg;
        st_next.sram_en = 1'b0;
        st_next.sram_we = 1'b0;
        st_next.reg_en  = 1'b0;
        // page pointer writes; nothing saves these on interrupt
        if (current_page_pointer_we_i) st_next.current_page_pointer = pp_wdata_i;
        if (stack_page_pointer_we_i) st_next.stack_page_pointer = pp_wdata_i;
        if (index_page_pointer_we_i) st_next.index_page_pointer = pp_wdata_i;
        if (move_read_page_pointer_we_i) st_next.move_read_page_pointer = pp_wdata_i;
        if (move_write_page_pointer_we_i) st_next.move_write_page_pointer = pp_wdata_i;
        // flags: interrupt entry beats other flag sources
        if (irq_entry_i) begin
            st_next.flag_push = st_reg.flag;
            st_next.flag      = SPSEL_FLAG_INT;
        end else if (svc_entry_i) begin
            st_next.flag[SPSEL_MODE_HI:SPSEL_MODE_LO] = SPSEL_PM_00;
        end else if (return_from_interrupt_i) begin
            st_next.flag = return_from_interrupt_flag_i;
        end else if (flag_we_i) begin
            st_next.flag = flag_wdata_i;
        end
        // stack pointer wraps naturally in 8 bits, page untouched
        if (sp_push_i && !sp_pop_i) begin
            st_next.sp = st_reg.sp + 8'h01;
        end else if (sp_pop_i && !sp_push_i) begin
            st_next.sp = st_reg.sp - 8'h01;
        end
        // single cpu access, one cycle later on the memory side
        if (acc_valid_i && !st_reg.mv_st[1] && st_reg.mv_st[0]) begin
            if (acc_reg_space_i) begin
                st_next.reg_en   = 1'b1;
                st_next.reg_addr = acc_addr_i;
            end else begin
                st_next.sram_en   = 1'b1;
                st_next.sram_addr = {page_sel, acc_addr_i};
            end
        end
        // move sequencer: pointer read, pointer write back, data
        case (st_reg.mv_st)
            SPSEL_MV_IDLE: begin
                if (mv_start_i) begin
                    st_next.mv_rd     = mv_is_read_i;
                    st_next.mv_ptr    = mv_ptr_addr_i;
                    st_next.sram_en   = 1'b1;
                    st_next.sram_addr = {(mode[1] ? st_reg.current_page_pointer
                                          : SPSEL_PAGE0[PAGE_W-1:0]),
                                         mv_ptr_addr_i};
                    st_next.mv_st     = SPSEL_MV_PRD;
                end
            end
            SPSEL_MV_PRD: begin
                // pointer value returns now; write it back incremented
                st_next.mv_data_addr = mv_ptr_rdata_i;
                st_next.sram_en      = 1'b1;
                st_next.sram_we      = 1'b1;
                st_next.sram_wdata   = mv_ptr_rdata_i + 8'h01;
                st_next.sram_addr    = {(mode[1] ? st_reg.current_page_pointer
                                          : SPSEL_PAGE0[PAGE_W-1:0]),
                                         st_reg.mv_ptr};
                st_next.mv_st        = SPSEL_MV_PWR;
            end
            SPSEL_MV_PWR: begin
                st_next.sram_en   = 1'b1;
                st_next.sram_we   = !st_reg.mv_rd;
                st_next.sram_addr = {(st_reg.mv_rd ? st_reg.move_read_page_pointer
                                      : st_reg.move_write_page_pointer),
                                     st_reg.mv_data_addr};
                st_next.mv_st     = SPSEL_MV_DATA;
            end
            SPSEL_MV_DATA: begin
                st_next.mv_st = SPSEL_MV_IDLE;
            end
            default: begin
                st_next.mv_st = SPSEL_MV_IDLE;
            end
        endcase
    end

    // state register; all fields take constants under reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg              <= '0;
            st_reg.flag         <= SPSEL_FLAG_RST;
            st_reg.stack_page_pointer       <= SPSEL_PP_RST;
            st_reg.current_page_pointer       <= SPSEL_PP_RST;
            st_reg.index_page_pointer       <= SPSEL_PP_RST;
            st_reg.move_read_page_pointer       <= SPSEL_PP_RST;
            st_reg.move_write_page_pointer       <= SPSEL_PP_RST;
            st_reg.sp           <= SPSEL_SP_RST;
            st_reg.mv_st        <= SPSEL_MV_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops, except mv_busy_o, the inverted idle bit of mv_st
    assign sram_en_o            = st_reg.sram_en;
    assign sram_we_o            = st_reg.sram_we;
    assign sram_addr_o          = st_reg.sram_addr;
    assign sram_wdata_o         = st_reg.sram_wdata;
    assign reg_en_o             = st_reg.reg_en;
    assign reg_addr_o           = st_reg.reg_addr;
    assign flag_o               = st_reg.flag;
    assign flag_push_o          = st_reg.flag_push;
    assign stack_pointer_o      = st_reg.sp;
    assign stack_page_pointer_o = st_reg.stack_page_pointer;
    assign mv_busy_o            = !st_reg.mv_st[0];

    // interrupt entry clears flags next cycle, old value pushed
    a_irq_clears_flags: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        irq_entry_i |=> (flag_o == 8'h00) && (flag_push_o == $past(flag_o)))
        else $error("interrupt entry did not save and clear flags");

    // return restores the value handed back
    a_return_from_interrupt_restores: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (return_from_interrupt_i && !irq_entry_i && !svc_entry_i)
        |=> flag_o == $past(return_from_interrupt_flag_i))
        else $error("return did not restore flags");

    // stack access lands on the stack page
    a_stack_page: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (acc_valid_i && acc_kind_i == SPSEL_ACC_STACK && !acc_reg_space_i
         && !mv_busy_o && !mv_start_i)
        |=> sram_en_o && sram_addr_o[10:8] == $past(stack_page_pointer_o))
        else $error("stack access on wrong page");

    // normal access in modes 0x stays on page zero
    a_normal_page0: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (acc_valid_i && acc_kind_i == SPSEL_ACC_NORMAL && !acc_reg_space_i
         && !mv_busy_o && !mv_start_i && !flag_o[7])
        |=> sram_addr_o[10:8] == 3'h0)
        else $error("normal access left page zero");

    // pop at zero wraps to ff
    a_sp_wrap: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (sp_pop_i && !sp_push_i && stack_pointer_o == 8'h00)
        |=> stack_pointer_o == 8'hff)
        else $error("stack pointer did not wrap");

    // move runs three sram accesses back to back then idles
    a_move_three: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (mv_start_i && !mv_busy_o) |=> sram_en_o[*3] ##1 !mv_busy_o)
        else $error("move sequence length wrong");

    // supervisor call forces mode 00
    a_svc_mode: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (svc_entry_i && !irq_entry_i) |=> flag_o[7:6] == 2'h0)
        else $error("supervisor call mode not 00");

    // register space access never touches sram
    a_reg_unpaged: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (acc_valid_i && acc_reg_space_i && !mv_busy_o && !mv_start_i)
        |=> reg_en_o && !sram_en_o && reg_addr_o == $past(acc_addr_i))
        else $error("register access was paged");

    // indexed sram access in modes 01 and 11 lands on the stack page
    a_index_stack: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (acc_valid_i && acc_kind_i == SPSEL_ACC_INDEX && !acc_reg_space_i
         && !mv_busy_o && !mv_start_i && flag_o[6])
        |=> sram_en_o && sram_addr_o[10:8] == $past(stack_page_pointer_o))
        else $error("indexed access on wrong page");

    // a move into the accumulator reads its data on the read page
    a_move_rd_page: assert property (@(posedge sys_clk_i)
        disable iff (!rstn_i)
        (mv_start_i && !mv_busy_o && mv_is_read_i)
        |-> ##3 (sram_en_o && !sram_we_o
                 && sram_addr_o[10:8] == $past(st_reg.move_read_page_pointer)))
        else $error("move read data on wrong page");

endmodule : spsel_page_select

/* spsel_pkg.sv */
// spsel_pkg: constants and types for the sram page selection block.
// assumes one 100 MHz clock; shared by the design and its bench.
package spsel_pkg;
    localparam int          SPSEL_PAGE_W   = 3;      // page number width
    localparam int          SPSEL_ADDR_W   = 8;      // cpu data address width
    localparam int          SPSEL_FLAG_W   = 8;      // flag register width
    localparam int          SPSEL_MODE_HI  = 7;      // upper page mode bit
    localparam int          SPSEL_MODE_LO  = 6;      // lower page mode bit
    localparam logic [7:0]  SPSEL_FLAG_RST = 8'h00;  // flags after reset
    localparam logic [7:0]  SPSEL_FLAG_INT = 8'h00;  // flags on interrupt
    localparam logic [2:0]  SPSEL_PP_RST   = 3'h0;   // page pointers reset
    localparam logic [7:0]  SPSEL_SP_RST   = 8'h00;  // stack pointer reset
    localparam logic [2:0]  SPSEL_PAGE0    = 3'h0;   // page zero
    localparam logic [1:0]  SPSEL_PM_00    = 2'h0;   // page mode encodings
    localparam logic [1:0]  SPSEL_PM_01    = 2'h1;
    localparam logic [1:0]  SPSEL_PM_10    = 2'h2;
    localparam logic [1:0]  SPSEL_PM_11    = 2'h3;

    // access kinds issued by the cpu core
    typedef enum logic [2:0] {
        SPSEL_ACC_NORMAL = 3'h0,  // plain data access
        SPSEL_ACC_STACK  = 3'h1,  // stack pointer based
        SPSEL_ACC_INDEX  = 3'h2,  // indexed sram access
        SPSEL_ACC_MVPTR  = 3'h3,  // move pointer read or write back
        SPSEL_ACC_MVRD   = 3'h4,  // move data read into accumulator
        SPSEL_ACC_MVWR   = 3'h5   // move data write from accumulator
    } spsel_acc_t;

    // move sequencer states, one-hot
    typedef enum logic [3:0] {
        SPSEL_MV_IDLE = 4'h1,
        SPSEL_MV_PRD  = 4'h2,
        SPSEL_MV_PWR  = 4'h4,
        SPSEL_MV_DATA = 4'h8
    } spsel_mv_t;
endpackage : spsel_pkg

/* spsel_sram_model.sv */
// spsel_sram_model: behavioural eight-page sram behind the page selector.
// assumes registered one-cycle strobes from the design on sys_clk_i.
module spsel_sram_model (
    input  wire logic        sys_clk_i,
    input  wire logic        sram_en_i,
    input  wire logic        sram_we_i,
    input  wire logic [10:0] sram_addr_i,
    input  wire logic [7:0]  sram_wdata_i,
    output logic      [7:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [2048];     // eight pages of 256 bytes
    logic [7:0] junk = 8'h5a;   // stands in for an undriven read bus

    // fixed fill so the bench can tell pointers apart
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = i[7:0] ^ 8'h3c;
        end
    end

    // writes land at the edge; junk toggles so stale data never matches
    always @(posedge sys_clk_i) begin
        junk <= ~junk;
        if (sram_we_i) begin
            mem[sram_addr_i] <= sram_wdata_i;
        end
    end

    // reads answer inside the cycle in which the strobe stands
    assign rdata_o = (sram_en_i && !sram_we_i) ? mem[sram_addr_i] : junk;
endmodule : spsel_sram_model

/* test_sram_page_select_logic.sv */
// test_sram_page_select_logic: self-checking bench for spsel_page_select.
// assumes spsel_sram_model answers move pointer reads; one 100 MHz clock.
module test_sram_page_select_logic
    import spsel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0;  // bench clock
    logic        rstn_i    = 1'b0;  // held low at start
    logic        acc_valid = 1'b0, acc_reg = 1'b0, flag_we = 1'b0;
    logic        mv_start  = 1'b0, mv_rd = 1'b0;
    logic [4:0]  evt       = 5'h00;  // irq, return_from_interrupt, svc, push, pop
    logic [4:0]  pp_we     = 5'h00;  // cur, stk, idx, mvr, mvw
    logic [2:0]  pp_wd     = 3'h0;
    logic [7:0]  acc_addr  = 8'h00, flag_wd = 8'h00, return_from_interrupt_flag = 8'h00;
    logic [7:0]  mv_addr   = 8'h00;
    spsel_acc_t  acc_kind  = SPSEL_ACC_NORMAL;
    logic        sram_en, sram_we, reg_en, busy;  // design outputs
    logic [10:0] sram_addr;
    logic [7:0]  sram_wd, reg_addr, flag, flag_push, sp, rdata;
    logic [2:0]  stack_page_pointer;
    int          err_total = 0, checks_done = 0;
    int          seed = 76073;             // lfsr state
    int          pg[5] = '{0, 0, 0, 0, 0};  // model page pointers
    int          mode = 0;                  // model page mode bits
    int          old_cur;                   // handler's saved pointer
    logic [7:0]  saved[$];                  // model of pushed flags

    always #5 sys_clk_i = ~sys_clk_i;

    spsel_page_select i_spsel_page_select (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .acc_valid_i(acc_valid), .acc_kind_i(acc_kind),
        .acc_reg_space_i(acc_reg), .acc_addr_i(acc_addr),
        .current_page_pointer_we_i(pp_we[0]), .stack_page_pointer_we_i(pp_we[1]),
        .index_page_pointer_we_i(pp_we[2]), .move_read_page_pointer_we_i(pp_we[3]),
        .move_write_page_pointer_we_i(pp_we[4]), .pp_wdata_i(pp_wd),
        .flag_we_i(flag_we), .flag_wdata_i(flag_wd),
        .irq_entry_i(evt[0]), .return_from_interrupt_i(evt[1]), .return_from_interrupt_flag_i(return_from_interrupt_flag),
        .svc_entry_i(evt[2]), .sp_push_i(evt[3]), .sp_pop_i(evt[4]),
        .mv_start_i(mv_start), .mv_is_read_i(mv_rd),
        .mv_ptr_addr_i(mv_addr), .mv_ptr_rdata_i(rdata),
        .sram_en_o(sram_en), .sram_we_o(sram_we),
        .sram_addr_o(sram_addr), .sram_wdata_o(sram_wd),
        .reg_en_o(reg_en), .reg_addr_o(reg_addr),
        .flag_o(flag), .flag_push_o(flag_push),
        .stack_pointer_o(sp), .stack_page_pointer_o(stack_page_pointer),
        .mv_busy_o(busy)
    );

    spsel_sram_model i_spsel_sram_model (
        .sys_clk_i(sys_clk_i), .sram_en_i(sram_en), .sram_we_i(sram_we),
        .sram_addr_i(sram_addr), .sram_wdata_i(sram_wd), .rdata_o(rdata)
    );

    // one comparison; case inequality so an unknown never matches
    task automatic chk(input string what, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    function automatic int lfsr(input int x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // page the model expects for a single access of kind k
    function automatic int exp_page(input spsel_acc_t k);
        if (k == SPSEL_ACC_STACK) return pg[1];
        if (k == SPSEL_ACC_MVRD) return pg[3];
        if (k == SPSEL_ACC_MVWR) return pg[4];
        if (k == SPSEL_ACC_INDEX)
            return (mode == 0) ? 0 : (mode == 2) ? pg[2] : pg[1];
        return mode[1] ? pg[0] : 0;
    endfunction : exp_page

    task automatic set_pp(input int n, input int v);
        @(posedge sys_clk_i);
        pp_we <= 5'h01 << n;
        pp_wd <= v[2:0];
        @(posedge sys_clk_i);
        pp_we <= 5'h00;
        pg[n] = v & 7;
    endtask : set_pp

    task automatic set_flag(input logic [7:0] v);
        @(posedge sys_clk_i);
        flag_we <= 1'b1;
        flag_wd <= v;
        @(posedge sys_clk_i);
        flag_we <= 1'b0;
        mode = v[7:6];
    endtask : set_flag

    // one-cycle control strobe w; f rides along as the popped flags
    task automatic ev(input int w, input logic [7:0] f);
        @(posedge sys_clk_i);
        evt <= 5'h01 << w;
        return_from_interrupt_flag <= f;
        @(posedge sys_clk_i);
        evt <= 5'h00;
        #1;
    endtask : ev

    task automatic access(input spsel_acc_t k, input logic r);
        int p;
        p = exp_page(k);
        seed = lfsr(seed);
        @(posedge sys_clk_i);
        acc_valid <= 1'b1;
        acc_kind <= k;
        acc_reg <= r;
        acc_addr <= seed[7:0];
        @(posedge sys_clk_i);
        acc_valid <= 1'b0;
        #1;
        if (r) begin
            chk("reg access", {1'b1, seed[7:0]}, {reg_en, reg_addr});
            chk("sram_en", 0, sram_en);
        end else begin
            chk("sram access", {1'b1, p[2:0], seed[7:0]},
                {sram_en, sram_addr});
        end
    endtask : access

    // auto_increment_move: pointer read, write back, then data access
    task automatic move(input logic rd);
        logic [7:0] v;
        int p;
        int d;
        p = mode[1] ? pg[0] : 0;
        d = rd ? pg[3] : pg[4];
        seed = lfsr(seed);
        @(posedge sys_clk_i);
        mv_start <= 1'b1;
        mv_rd <= rd;
        mv_addr <= seed[7:0];
        @(posedge sys_clk_i);
        mv_start <= 1'b0;
        #1;
        v = rdata;
        chk("ptr read", {3'b110, p[2:0], seed[7:0]},
            {busy, sram_en, sram_we, sram_addr});
        @(posedge sys_clk_i);
        #1;
        chk("ptr write", {1'b1, p[2:0], seed[7:0]},
            {sram_we, sram_addr});
        chk("ptr value", 8'(v + 8'h01), sram_wd);
        @(posedge sys_clk_i);
        #1;
        chk("move data", {1'b1, ~rd, d[2:0], v},
            {sram_en, sram_we, sram_addr});
        @(posedge sys_clk_i);
        #1;
        chk("mv_busy", 0, busy);
    endtask : move

    // watchdog: a hang counts as a mismatch
    initial begin
        #100us;
        err_total++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk("flag", 0, flag);
        chk("stack page", {3'h0, 8'h00}, {stack_page_pointer, sp});
        set_pp(1, 5);
        set_pp(0, 6);
        set_pp(2, 7);
        access(SPSEL_ACC_NORMAL, 1'b0);
        access(SPSEL_ACC_INDEX, 1'b0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            for (int n = 0; n < 5; n++) begin
                seed = lfsr(seed);
                if (n != 1) set_pp(n, seed);
            end
            set_flag({m[1:0], 6'h15});
            access(SPSEL_ACC_NORMAL, 1'b0);
            access(SPSEL_ACC_INDEX, 1'b0);
            access(SPSEL_ACC_INDEX, 1'b1);
            access(SPSEL_ACC_STACK, 1'b0);
            access(SPSEL_ACC_MVPTR, 1'b0);
            access(SPSEL_ACC_MVRD, 1'b0);
            access(SPSEL_ACC_MVWR, 1'b0);
            chk("flag", {m[1:0], 6'h15}, flag);
            move(1'b1);
            move(1'b0);
        end
        $display("test paging done");
        ev(4, 8'h00);
        chk("stack pointer", 8'hff, sp);
        ev(3, 8'h00);
        chk("stack pointer", 8'h00, sp);
        $display("test stack done");
        set_flag(8'hc3);
        ev(0, 8'h00);
        saved.push_back(8'hc3);
        mode = 0;
        chk("flag", {8'h00, 8'hc3}, {flag, flag_push});
        access(SPSEL_ACC_NORMAL, 1'b0);
        old_cur = pg[0];
        set_pp(0, old_cur + 1);
        set_flag(8'h41);
        access(SPSEL_ACC_INDEX, 1'b0);
        set_pp(0, old_cur);
        ev(1, saved.pop_back());
        mode = 3;
        chk("flag", 8'hc3, flag);
        access(SPSEL_ACC_NORMAL, 1'b0);
        $display("test interrupt done");
        set_flag(8'hff);
        ev(2, 8'h00);
        mode = 0;
        chk("flag", 8'h3f, flag);
        $display("test supervisor done");
        // a second reset in mid-run must bring back page zero everywhere
        rstn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        chk("flag", 0, flag);
        chk("stack page", 0, stack_page_pointer);
        pg = '{0, 0, 0, 0, 0};
        mode = 0;
        access(SPSEL_ACC_INDEX, 1'b0);
        access(SPSEL_ACC_STACK, 1'b0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : test_sram_page_select_logic
